// ===== core/hs_uart_rx_status_pkg.sv
// Constants and carrier types of the receive status flag block.
// Assumes a 32-bit APB slave port and one 40 MHz clock.
package hs_uart_rx_status_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CTRL    = 32'hF008_0000; // Serial control register
  localparam logic [31:0] ADDR_STATUS  = 32'hF008_0004; // Receive status register
  localparam logic [31:0] ADDR_RX_DATA = 32'hF008_0008; // Holding buffer or queue head
  localparam logic [31:0] ADDR_IRQ_EN  = 32'hF008_000C; // Interrupt enable register

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000; // All modes off
  localparam logic [6:0]  IRQ_EN_RESET = 7'h00;          // All sources masked
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000; // Unmapped read value

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LO  = 2;  // Receive mode field low bit
  localparam int CTRL_MODE_HI  = 3;  // Receive mode field high bit
  localparam int CTRL_CHAR_LO  = 8;  // Programmed control character low bit
  localparam int CTRL_CHAR_HI  = 15; // Programmed control character high bit
  localparam int CTRL_QUEUE_EN = 17; // Receive queue enable

  // Receive mode encodings
  localparam logic [1:0] MODE_IRQ = 2'h1; // Interrupt request mode
  localparam int         MODE_DMA = 1;    // Mode bit that selects DMA (10 or 11)

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_VALID   = 0; // Receive data valid
  localparam int ST_BREAK   = 1; // Break received
  localparam int ST_FRAME   = 2; // Framing error
  localparam int ST_PARITY  = 3; // Parity error
  localparam int ST_OVERRUN = 4; // Overrun
  localparam int ST_CTRL    = 5; // Control character seen
  localparam int ST_CARRIER = 6; // Carrier lost
  localparam int ST_WIDTH   = 7; // Implemented status bits

  // ----------------------------------------------------------------
  // Data path sizes
  // ----------------------------------------------------------------
  localparam int CHAR_WIDTH  = 8;  // Received character width
  localparam int QUEUE_DEPTH = 32; // Receive queue entries

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // One validated character from the receiver core
  typedef struct packed {
    logic                  valid;  // One-cycle pulse: frame validated
    logic                  brk;    // Break condition with this frame
    logic                  frame;  // Stop bit sampled as zero
    logic                  parity; // Parity check failed
    logic [CHAR_WIDTH-1:0] data;   // Received character
  } rx_event_type;

  // APB request from the master
  typedef struct packed {
    logic        psel;    // Slave selected
    logic        penable; // Access phase
    logic        pwrite;  // Write when high
    logic [31:0] paddr;   // Byte address
    logic [31:0] pwdata;  // Write data
  } apb_req_type;

endpackage : hs_uart_rx_status_pkg

// ===== core/rx_queue_store.sv
// Receive queue: a plain synchronous first-in first-out store.
// Drops a push when full and ignores a pop when empty, so the parent need not gate either.
`timescale 1ns/1ps
module rx_queue_store #(
  parameter int WIDTH = 8,  // Entry width
  parameter int DEPTH = 32  // Entry count
) (
  input  wire logic             clk_i,       // Core clock
  input  wire logic             srst_i,      // Synchronous reset
  input  wire logic             in_valid_i,  // Push request
  input  wire logic [WIDTH-1:0] in_data_i,   // Push data
  output logic                  in_ready_o,  // Space left
  output logic                  out_valid_o, // Head holds data
  output logic [WIDTH-1:0]      out_data_o,  // Head data
  input  wire logic             out_ready_i  // Pop request
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Entry array
  logic [PW-1:0]    wr_ptr;       // Next free entry
  logic [PW-1:0]    rd_ptr;       // Head entry
  logic [PW:0]      count;        // Entries held

  wire push = in_valid_i & in_ready_o;   // Accepted push
  wire pop  = out_ready_i & out_valid_o; // Accepted pop

  // Full compare at count width; a PW-bit DEPTH would wrap to zero
  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Pointer and count update
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop)  rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Entry write
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end

endmodule : rx_queue_store

// ===== core/hs_uart_rx_status_flags.sv
// Receive status flags of a high-speed serial port with an APB slave.
// Assumes the receiver core hands over one validated frame per pulse,
// with its error qualifiers, on the same 40 MHz clock.
`timescale 1ns/1ps

module hs_uart_rx_status_flags #(
  parameter int QUEUE_DEPTH = hs_uart_rx_status_pkg::QUEUE_DEPTH // Receive queue entries
) (
  input  wire logic                               clk_i,             // 40 MHz clock
  input  wire logic                               srst_i,            // Synchronous reset
  input  wire hs_uart_rx_status_pkg::apb_req_type apb_i,             // APB request
  output logic [31:0]                             prdata_o,          // APB read data
  output logic                                    pready_o,          // APB ready
  output logic                                    pslverr_o,         // APB error
  input  wire hs_uart_rx_status_pkg::rx_event_type rx_event_i,       // Validated frame
  input  wire logic                               carrier_detect_in_i, // Carrier pin level
  output logic                                    irq_o,             // Interrupt request
  output logic                                    dma_req_o          // DMA request
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] serial_control_reg;           // Mode, queue enable, control char
  logic [hs_uart_rx_status_pkg::ST_WIDTH-1:0] irq_enable_reg; // Per-source enables
  logic [hs_uart_rx_status_pkg::ST_WIDTH-1:1] sticky;         // Sticky event flags
  logic [hs_uart_rx_status_pkg::CHAR_WIDTH-1:0] rx_holding_buffer; // Non-queue data
  logic        hold_valid;                   // Holding buffer has unread data

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire sel_ctrl   = (apb_i.paddr == hs_uart_rx_status_pkg::ADDR_CTRL);
  wire sel_status = (apb_i.paddr == hs_uart_rx_status_pkg::ADDR_STATUS);
  wire sel_data   = (apb_i.paddr == hs_uart_rx_status_pkg::ADDR_RX_DATA);
  wire sel_irqen  = (apb_i.paddr == hs_uart_rx_status_pkg::ADDR_IRQ_EN);
  wire mapped     = sel_ctrl | sel_status | sel_data | sel_irqen;

  // Access phase completes at the edge where ready is seen high
  wire access_end = apb_i.psel & apb_i.penable & pready_o;
  wire wr_end     = access_end & apb_i.pwrite & mapped;
  wire rd_end     = access_end & ~apb_i.pwrite & mapped;
  wire wr_ctrl    = wr_end & sel_ctrl;
  wire wr_status  = wr_end & sel_status;
  wire wr_irqen   = wr_end & sel_irqen;
  wire rd_data    = rd_end & sel_data;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire [1:0] rx_mode = serial_control_reg[hs_uart_rx_status_pkg::CTRL_MODE_HI:
                                          hs_uart_rx_status_pkg::CTRL_MODE_LO];
  wire       queue_en = serial_control_reg[hs_uart_rx_status_pkg::CTRL_QUEUE_EN];
  wire [hs_uart_rx_status_pkg::CHAR_WIDTH-1:0] ctrl_char =
    serial_control_reg[hs_uart_rx_status_pkg::CTRL_CHAR_HI:hs_uart_rx_status_pkg::CTRL_CHAR_LO];

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  logic                                         q_ready; // Queue has space
  logic                                         q_valid; // Queue head valid
  logic [hs_uart_rx_status_pkg::CHAR_WIDTH-1:0] q_data;  // Queue head data

  wire q_push = rx_event_i.valid & queue_en;   // Frame goes to the queue
  wire q_pop  = rd_data & queue_en;            // Host read of queue head
  wire h_push = rx_event_i.valid & ~queue_en;  // Frame goes to holding buffer
  wire h_pop  = rd_data & ~queue_en;           // Host read of holding buffer

  rx_queue_store #(
    .WIDTH (hs_uart_rx_status_pkg::CHAR_WIDTH),
    .DEPTH (QUEUE_DEPTH)
  ) u_rx_queue (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (q_push),
    .in_data_i   (rx_event_i.data),
    .in_ready_o  (q_ready),
    .out_valid_o (q_valid),
    .out_data_o  (q_data),
    .out_ready_i (q_pop)
  );

  // ----------------------------------------------------------------
  // Flag sources
  // ----------------------------------------------------------------
  // Valid flag taken from queue head or holding buffer
  wire rx_valid_flag = queue_en ? q_valid : hold_valid;

  // Overrun: unread held data not read now, or full queue
  wire overrun_hit = (h_push & hold_valid & ~h_pop) | (q_push & ~q_ready);

  // Control character compare, report only
  wire ctrl_hit = rx_event_i.valid & (rx_event_i.data == ctrl_char);

  // Carrier pin high when a frame is validated
  wire carrier_hit = rx_event_i.valid & carrier_detect_in_i;

  // Set vector aligned with the sticky bits
  logic [hs_uart_rx_status_pkg::ST_WIDTH-1:1] ev_set;
  assign ev_set[hs_uart_rx_status_pkg::ST_BREAK]   = rx_event_i.valid & rx_event_i.brk;
  assign ev_set[hs_uart_rx_status_pkg::ST_FRAME]   = rx_event_i.valid & rx_event_i.frame;
  assign ev_set[hs_uart_rx_status_pkg::ST_PARITY]  = rx_event_i.valid & rx_event_i.parity;
  assign ev_set[hs_uart_rx_status_pkg::ST_OVERRUN] = overrun_hit;
  assign ev_set[hs_uart_rx_status_pkg::ST_CTRL]    = ctrl_hit;
  assign ev_set[hs_uart_rx_status_pkg::ST_CARRIER] = carrier_hit;

  // Write-one-clear mask from the status write
  wire [hs_uart_rx_status_pkg::ST_WIDTH-1:1] w1c =
    {(hs_uart_rx_status_pkg::ST_WIDTH-1){wr_status}} &
    apb_i.pwdata[hs_uart_rx_status_pkg::ST_WIDTH-1:1];

  // ----------------------------------------------------------------
  // Read mux and request terms
  // ----------------------------------------------------------------
  wire [hs_uart_rx_status_pkg::ST_WIDTH-1:0] status_word = {sticky, rx_valid_flag};
  wire [hs_uart_rx_status_pkg::CHAR_WIDTH-1:0] head_data = queue_en ? q_data
                                                                    : rx_holding_buffer;
  wire [31:0] rd_mux =
    sel_ctrl   ? serial_control_reg :
    sel_status ? {(32-hs_uart_rx_status_pkg::ST_WIDTH)'(0), status_word} :
    sel_data   ? {(32-hs_uart_rx_status_pkg::CHAR_WIDTH)'(0), head_data} :
    sel_irqen  ? {(32-hs_uart_rx_status_pkg::ST_WIDTH)'(0), irq_enable_reg} :
                 hs_uart_rx_status_pkg::READ_ZERO;

  // Interrupt sources: sticky flags plus valid in interrupt mode
  wire valid_irq = rx_valid_flag & (rx_mode == hs_uart_rx_status_pkg::MODE_IRQ) &
                   irq_enable_reg[hs_uart_rx_status_pkg::ST_VALID];
  wire next_irq  = valid_irq |
                   (|(sticky & irq_enable_reg[hs_uart_rx_status_pkg::ST_WIDTH-1:1]));
  wire next_dma  = rx_valid_flag & rx_mode[hs_uart_rx_status_pkg::MODE_DMA];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: ready is high in the second access cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= hs_uart_rx_status_pkg::READ_ZERO;
    end else begin
      pready_o  <= apb_i.psel & apb_i.penable & ~pready_o;
      pslverr_o <= apb_i.psel & apb_i.penable & ~pready_o & ~mapped;
      // Capture read data with ready; unmapped reads zero
      prdata_o  <= (apb_i.psel & apb_i.penable & ~pready_o & ~apb_i.pwrite) ?
                   rd_mux : hs_uart_rx_status_pkg::READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Software written registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      serial_control_reg <= hs_uart_rx_status_pkg::CTRL_RESET;
      irq_enable_reg     <= hs_uart_rx_status_pkg::IRQ_EN_RESET;
    end else begin
      if (wr_ctrl)  serial_control_reg <= apb_i.pwdata;
      if (wr_irqen) irq_enable_reg <= apb_i.pwdata[hs_uart_rx_status_pkg::ST_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Holding buffer
  // ----------------------------------------------------------------
  // New frame wins over a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_valid        <= 1'b0;
      rx_holding_buffer <= '0;
    end else if (h_push) begin
      hold_valid        <= 1'b1;
      rx_holding_buffer <= rx_event_i.data;  // Newest frame overwrites
    end else if (h_pop) begin
      hold_valid        <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  for (genvar i = 1; i < hs_uart_rx_status_pkg::ST_WIDTH; i++) begin : g_sticky
    always_ff @(posedge clk_i) begin
      if (srst_i) sticky[i] <= 1'b0;
      else        sticky[i] <= (sticky[i] & ~w1c[i]) | ev_set[i];
    end
  end

  // ----------------------------------------------------------------
  // Request outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o     <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      irq_o     <= next_irq;
      dma_req_o <= next_dma;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_valid_after_char: assert property (
    h_push |=> rx_valid_flag ##0 (hold_valid == 1'b1))
    else $error("valid flag not set after held frame");

  a_dma_on_valid: assert property (
    rx_valid_flag && rx_mode[hs_uart_rx_status_pkg::MODE_DMA] |=> dma_req_o)
    else $error("DMA request missing while data valid");

  a_irq_on_valid: assert property (
    rx_valid_flag && rx_mode == hs_uart_rx_status_pkg::MODE_IRQ &&
    irq_enable_reg[hs_uart_rx_status_pkg::ST_VALID] |=> irq_o)
    else $error("valid interrupt missing");

  a_read_clears_valid: assert property (
    h_pop && !h_push |=> !rx_valid_flag [*1] ##0 !hold_valid)
    else $error("read did not clear valid flag");

  a_queue_source_sel: assert property (
    q_push && q_ready && !q_pop |=> rx_valid_flag && $stable(hold_valid))
    else $error("queue frame not shown as valid");

  a_break_sets_flag: assert property (
    rx_event_i.valid && rx_event_i.brk |=> sticky[hs_uart_rx_status_pkg::ST_BREAK])
    else $error("break flag not set");

  a_frame_sets_flag: assert property (
    rx_event_i.valid && rx_event_i.frame |=> sticky[hs_uart_rx_status_pkg::ST_FRAME])
    else $error("framing flag not set");

  a_parity_sets_flag: assert property (
    rx_event_i.valid && rx_event_i.parity
    |=> sticky[hs_uart_rx_status_pkg::ST_PARITY] ##1 1'b1)
    else $error("parity flag not set");

  a_overrun_held_data: assert property (
    h_push && hold_valid && !h_pop |=> sticky[hs_uart_rx_status_pkg::ST_OVERRUN])
    else $error("overrun not flagged");

  a_overrun_irq_out: assert property (
    sticky[hs_uart_rx_status_pkg::ST_OVERRUN] &&
    irq_enable_reg[hs_uart_rx_status_pkg::ST_OVERRUN] |=> irq_o)
    else $error("overrun interrupt missing");

  a_ctrl_char_flag: assert property (
    rx_event_i.valid && rx_event_i.data == ctrl_char
    |=> sticky[hs_uart_rx_status_pkg::ST_CTRL])
    else $error("control character flag not set");

  a_carrier_lost_flag: assert property (
    rx_event_i.valid && carrier_detect_in_i
    |=> sticky[hs_uart_rx_status_pkg::ST_CARRIER] ##1 $past(rx_event_i.valid, 2))
    else $error("carrier lost flag not set");

  a_sticky_holds: assert property (
    sticky[hs_uart_rx_status_pkg::ST_FRAME] &&
    !w1c[hs_uart_rx_status_pkg::ST_FRAME] |=> sticky[hs_uart_rx_status_pkg::ST_FRAME])
    else $error("frame flag dropped without write");

endmodule : hs_uart_rx_status_flags

// ===== test/rx_frame_source.sv
// Remote serial device model: hands validated frames to the receiver.
// Assumes the bench calls send_frame from its procedural thread.
`timescale 1ns/1ps
module rx_frame_source (
  input  wire logic                           clk_i,    // Core clock
  output hs_uart_rx_status_pkg::rx_event_type event_o,  // Frame pulse and qualifiers
  output logic                                carrier_o // Carrier pin, high = lost
);
  // ----------------------------------------------------------------
  // Idle line
  // ----------------------------------------------------------------
  initial begin
    event_o   = '0;
    carrier_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: q = {carrier, brk, frame, parity}
  // ----------------------------------------------------------------
  // Brk, frame, parity and data go inverted after the pulse so stale values never match; carrier goes low
  task automatic send_frame(input logic [3:0] q, input logic [7:0] d);
    @(posedge clk_i);
    event_o   <= {1'b1, q[2:0], d};
    carrier_o <= q[3];
    @(posedge clk_i);
    event_o   <= {1'b0, ~q[2:0], ~d};
    carrier_o <= 1'b0;
  endtask : send_frame
endmodule : rx_frame_source

// ===== test/testbench.sv
// Self-checking bench of the receive status flag block.
// Assumes the APB slave answers with pready_o and one frame source.
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                               clk_i = 1'b0; // 40 MHz clock
  logic                               srst_i = 1'b1; // Reset
  hs_uart_rx_status_pkg::apb_req_type apb_req = '0;  // APB request
  hs_uart_rx_status_pkg::rx_event_type rx_ev;        // Frames from source
  logic        carrier;                              // Carrier pin
  logic [31:0] prdata_o;                             // Read data
  logic        pready_o;                             // Ready
  logic        pslverr_o;                            // Error
  logic        irq_o;                                // Interrupt
  logic        dma_req_o;                            // DMA request
  logic [31:0] r;                                    // Read scratch
  logic        e;                                    // Error scratch
  int          err_total = 0;                        // Mismatches
  int          checked = 0;                          // Comparisons

  always #12.5 clk_i = ~clk_i; // 25 ns period

  // Small queue so the full case comes quickly
  hs_uart_rx_status_flags #(.QUEUE_DEPTH(4)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .apb_i(apb_req), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_event_i(rx_ev),
    .carrier_detect_in_i(carrier), .irq_o(irq_o), .dma_req_o(dma_req_o));
  rx_frame_source u_src (.clk_i(clk_i), .event_o(rx_ev), .carrier_o(carrier));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // One APB transfer; answer taken at the edge where pready_o is high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_req.penable <= 1'b1;
    // Request held until ready is seen at a rising edge; watchdog ends a hang
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    r = prdata_o;
    e = pslverr_o;
    apb_req <= '0;
  endtask : apb

  task automatic settle;
    repeat (3) @(negedge clk_i);
  endtask : settle

  task automatic rds(input logic [31:0] x);
    apb(1'b0, hs_uart_rx_status_pkg::ADDR_STATUS, '0);
    chk("status", r, x);
  endtask : rds

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_errors;
    rds(32'h0000_0000);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_IRQ_EN, 32'h0000_000E);
    u_src.send_frame(4'h7, 8'h55);
    rds(32'h0000_000F);
    settle();
    chk("irq", irq_o, 1'b1);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_STATUS, 32'h0000_0000);
    rds(32'h0000_000F);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_STATUS, 32'h0000_000E);
    rds(32'h0000_0001);
    settle();
    chk("irq", irq_o, 1'b0);
    apb(1'b0, hs_uart_rx_status_pkg::ADDR_RX_DATA, '0);
    chk("data", r, 32'h0000_0055);
    rds(32'h0000_0000);
  endtask : t_errors

  task automatic t_overrun;
    u_src.send_frame(4'h0, 8'h11);
    u_src.send_frame(4'h0, 8'h22);
    rds(32'h0000_0011);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_IRQ_EN, 32'h0000_0010);
    settle();
    chk("irq", irq_o, 1'b1);
    apb(1'b0, hs_uart_rx_status_pkg::ADDR_RX_DATA, '0);
    chk("data", r, 32'h0000_0022);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_STATUS, 32'h0000_0010);
    rds(32'h0000_0000);
  endtask : t_overrun

  task automatic t_ctrl_carrier;
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_CTRL, 32'h0000_7E00);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_IRQ_EN, 32'h0000_0040);
    u_src.send_frame(4'h8, 8'h7E);
    rds(32'h0000_0061);
    settle();
    chk("irq", irq_o, 1'b1);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_STATUS, 32'h0000_0040);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_IRQ_EN, 32'h0000_0020);
    settle();
    chk("irq", irq_o, 1'b1);
    u_src.send_frame(4'h0, 8'h33);
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_STATUS, 32'h0000_0030);
    apb(1'b0, hs_uart_rx_status_pkg::ADDR_RX_DATA, '0);
    chk("data", r, 32'h0000_0033);
    rds(32'h0000_0000);
  endtask : t_ctrl_carrier

  task automatic t_modes;
    logic [1:0] m;
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      apb(1'b1, hs_uart_rx_status_pkg::ADDR_CTRL, {28'h0, m, 2'b00});
      u_src.send_frame(4'h0, 8'hA0);
      settle();
      chk("irq", irq_o, m == 2'b01);
      chk("dma", dma_req_o, m[1]);
      apb(1'b0, hs_uart_rx_status_pkg::ADDR_RX_DATA, '0);
      settle();
      chk("dma", dma_req_o | irq_o, 1'b0);
    end
  endtask : t_modes

  task automatic t_queue;
    apb(1'b1, hs_uart_rx_status_pkg::ADDR_CTRL, 32'h0002_0000);
    for (int i = 0; i < 5; i++) u_src.send_frame(4'h0, 8'(i + 1));
    rds(32'h0000_0011);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, hs_uart_rx_status_pkg::ADDR_RX_DATA, '0);
      chk("queue", r, 32'(i + 1));
    end
    rds(32'h0000_0010);
    apb(1'b1, 32'hF008_0010, 32'h0000_00FF);
    chk("slverr", e, 1'b1);
    apb(1'b0, 32'hF008_0010, '0);
    chk("unmapped", r, 32'h0000_0000);
  endtask : t_queue

  // ----------------------------------------------------------------
  // Verdict and run control
  // ----------------------------------------------------------------
  task automatic close_out;
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    chk("irq", irq_o | dma_req_o, 1'b0);
    t_errors();
    t_overrun();
    t_ctrl_carrier();
    t_modes();
    t_queue();
    close_out();
  end
endmodule : testbench
